/* File: dv/idts_drive_model.sv */
// Behavioural drive on one channel: answers each strobe with its ready line.
// Assumes strobes are one-cycle pulses in the host clock domain.
`timescale 1ns/1ps
module idts_drive_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [2:0] wait_clks,
  output logic iordy
);
  logic [2:0] busy_r; // Clocks left before the drive is ready
  logic [2:0] busy_nxt; // Next value of the count

  // Reload on each strobe, else count down and stop at zero
  always_comb begin
    busy_nxt = busy_r;
    if (strobe) begin
      busy_nxt = wait_clks;
    end else if (busy_r != 3'h0) begin
      busy_nxt = busy_r - 3'h1;
    end
  end

  // Registered count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 3'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // Line has a pull-up, so idle reads ready; a slow drive holds it low
  assign iordy = (busy_r == 3'h0);
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the drive timing selection block.
// Assumes the bench is the only register master and task-file source.
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acc_req = 1'b0;
  logic acc_data_port = 1'b0;
  logic acc_dma = 1'b0;
  logic acc_write = 1'b0;
  logic [2:0] acc_port = 3'h0;
  logic [7:0] acc_wdata = 8'h00;
  logic io_strobe = 1'b0;
  logic [2:0] wait_clks = 3'h0; // How slow the drive answers
  logic [15:0] reg_rdata;
  logic iordy;
  logic drv_sel, acc_fast, acc_wide16, acc_prefetch, acc_rdy_en, rdy_sample, rdy_ok;
  logic [2:0] acc_sample_clks, acc_recov_clks;
  logic [15:0] q_rd[$]; // Expected read data
  logic [15:0] q_acc[$]; // Expected decisions
  logic [15:0] q_rdy[$]; // Expected {clocks, ready}
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] chan_m = 16'h0000; // Mirror of the channel register
  logic [7:0] slave_m = 8'h00; // Mirror of the slave register
  logic drv_m = 1'b0; // Mirror of the drive select copy

  idts_top #(.CHAN_SEC(1'b0)) idts_top_i (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ACC_REQ(acc_req),
    .ACC_DATA_PORT(acc_data_port), .ACC_DMA(acc_dma), .ACC_WRITE(acc_write), .ACC_PORT(acc_port),
    .ACC_WDATA(acc_wdata), .IO_STROBE(io_strobe), .IORDY_PIN(iordy), .DRV_SEL(drv_sel),
    .ACC_FAST(acc_fast), .ACC_WIDE16(acc_wide16), .ACC_PREFETCH(acc_prefetch),
    .ACC_SAMPLE_CLKS(acc_sample_clks), .ACC_RECOV_CLKS(acc_recov_clks), .ACC_RDY_EN(acc_rdy_en),
    .RDY_SAMPLE(rdy_sample), .RDY_OK(rdy_ok));

  idts_drive_model idts_drive_model_i (.clk(clk_sys), .rst(sys_rst), .strobe(io_strobe),
    .wait_clks(wait_clks), .iordy(iordy));

  // Free-running 50 MHz clock
  initial begin
    forever begin
      #10 clk_sys = ~clk_sys;
    end
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One comparison; four-state so an unknown never matches
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected decision, worked from the field meanings, plus new drive
  function automatic logic [15:0] decide(input logic d, input logic data, input logic dma, input logic nd);
    logic [3:0] t;
    logic [1:0] ready_sample_point;
    logic [1:0] rcv;
    t = d ? chan_m[7:4] : chan_m[3:0]; // {dma only, prefetch, ready, fast}
    ready_sample_point = chan_m[13:12];
    rcv = chan_m[9:8];
    if (d && chan_m[14]) begin
      ready_sample_point = slave_m[3:2];
      rcv = slave_m[1:0];
    end
    decide = {5'h00, nd, data && t[0] && (dma || !t[3]), data, data && t[2],
      3'h5 - {1'b0, ready_sample_point}, 3'h4 - {1'b0, rcv}, t[1]};
  endfunction

  // All strobes set once per cycle, so back-to-back calls never clash
  task automatic step(input logic [3:0] s);
    {reg_wr, reg_rd, acc_req, io_strobe} <= s;
    @(posedge clk_sys);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    if (a == idts_pkg::OFS_CHAN) chan_m = d & idts_pkg::CHAN_WMASK;
    if (a == idts_pkg::OFS_SLAVE) slave_m = d[7:0];
    step(4'h8);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    q_rd.push_back(e);
    step(4'h4);
  endtask

  // Task-file access; hd makes it a drive/head write selecting d1
  task automatic acc(input logic data, input logic dma, input logic hd, input logic d1);
    logic nd;
    nd = hd ? d1 : drv_m;
    acc_data_port <= data && !hd;
    acc_dma <= dma;
    acc_write <= hd | 1'($urandom);
    acc_port <= hd ? idts_pkg::DRVHEAD_PORT : 3'($urandom_range(0, 5));
    acc_wdata <= {3'($urandom), d1, 4'($urandom)};
    q_acc.push_back(decide(drv_m, data && !hd, dma, nd));
    drv_m = nd;
    step(4'h2);
  endtask

  // Ready sample on drive 0 with a drive that answers after w clocks
  task automatic smp(input logic [1:0] code, input logic ie, input logic [2:0] w);
    logic [2:0] n;
    n = 3'h5 - {1'b0, code};
    wreg(idts_pkg::OFS_CHAN, {2'b00, code, 12'h000} | {14'h0000, ie, 1'b0});
    acc(1'b0, 1'b0, 1'b1, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 1'b0);
    wait_clks <= w;
    q_rdy.push_back({12'h000, n, !ie || (w < n)});
    step(4'h1);
    for (int i = 0; i < 10 && q_rdy.size() != 0; i++) begin
      step(4'h0);
    end
  endtask

  // Watcher: each result taken against the oldest note
  initial begin
    logic prd;
    logic pacc;
    logic [3:0] cnt;
    prd = 1'b0;
    pacc = 1'b0;
    cnt = 4'h0;
    // Outputs are unknown until the first reset edge, so start watching after it
    wait (sys_rst == 1'b0);
    forever begin
      @(posedge clk_sys);
      chk(reg_rdata, prd ? q_rd.pop_front() : 16'h0000);
      if (pacc) chk({5'h00, drv_sel, acc_fast, acc_wide16, acc_prefetch, acc_sample_clks, acc_recov_clks,
        acc_rdy_en}, q_acc.pop_front());
      if (rdy_sample) chk({11'h000, cnt, rdy_ok}, q_rdy.pop_front());
      // Zero at the strobe edge, so the pulse sees the clocks up to the sample edge
      cnt = io_strobe ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
      prd = reg_rd;
      pacc = acc_req;
    end
  end

  // Main sequence
  initial begin
    void'($urandom(42956));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values, read-only status, unmapped place
    rreg(idts_pkg::OFS_CHAN, 16'h0000);
    rreg(idts_pkg::OFS_SLAVE, 16'h0000);
    rreg(idts_pkg::OFS_STATUS, 16'h0020);
    wreg(8'h50, 16'hFFFF);
    rreg(8'h50, 16'h0000);
    wreg(idts_pkg::OFS_SLAVE, 16'hFF5A);
    rreg(idts_pkg::OFS_SLAVE, 16'h005A);
    wreg(idts_pkg::OFS_CHAN, 16'hFFFF);
    rreg(idts_pkg::OFS_CHAN, 16'h73FF);
    // Random settings, drive switches and accesses, back to back
    repeat (150) begin
      if ($urandom_range(0, 3) == 0) wreg(idts_pkg::OFS_CHAN, 16'($urandom));
      if ($urandom_range(0, 3) == 0) wreg(idts_pkg::OFS_SLAVE, 16'($urandom));
      acc(1'($urandom), 1'($urandom), $urandom_range(0, 2) == 0, 1'($urandom));
    end
    // Every sample point code, sampling on and off, drive just in time and late
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        smp(2'(c), k[0], 3'(4 - c + k[1]));
      end
    end
    repeat (3) step(4'h0);
    chk(16'(q_rd.size() + q_acc.size() + q_rdy.size()), 16'h0000);
    give_verdict();
  end
endmodule

/* File: hw/idts_decode.sv */
// Combinational timing decision for one task-file access.
// Assumes the caller registers the result; no state is held here.
`timescale 1ns/1ps
module idts_decode (
  input wire logic [15:0] chan,
  input wire logic [7:0] slave,
  input wire logic sec,
  input wire logic drv,
  input wire logic data_port,
  input wire logic dma,
  output logic fast,
  output logic wide16,
  output logic prefetch,
  output logic [1:0] isp_code,
  output logic [1:0] rcv_code,
  output logic rdy_en
);
  logic sel_fast; // Fast bank bit of the selected drive
  logic sel_dmao; // DMA-only timing bit of the selected drive
  logic sel_pp; // Prefetch/posting bit of the selected drive
  logic [3:0] slv_nib; // Slave nibble of this channel

  // Pick the per-drive bits, then decide
  always_comb begin
    sel_fast = drv ? chan[idts_pkg::BIT_DRV1_FAST] : chan[idts_pkg::BIT_DRV0_FAST];
    sel_dmao = drv ? chan[idts_pkg::BIT_DRV1_DMAO] : chan[idts_pkg::BIT_DRV0_DMAO];
    sel_pp = drv ? chan[idts_pkg::BIT_DRV1_PP] : chan[idts_pkg::BIT_DRV0_PP];
    slv_nib = sec ? slave[7:4] : slave[3:0];
    // Fast only on the data port, and PIO only without DMA-only timing
    fast = data_port && sel_fast && (dma || !sel_dmao);
    // Data port is 16-bit wide, every other port 8-bit compatible
    wide16 = data_port;
    prefetch = data_port && sel_pp;
    rdy_en = drv ? chan[idts_pkg::BIT_DRV1_RDY] : chan[idts_pkg::BIT_DRV0_RDY];
    // Slave register only counts for drive 1 with the enable set
    if (drv && chan[idts_pkg::BIT_SLV_EN]) begin
      isp_code = slv_nib[idts_pkg::SLV_ISP_LSB +: 2];
      rcv_code = slv_nib[idts_pkg::SLV_RCV_LSB +: 2];
    end else begin
      isp_code = chan[idts_pkg::ISP_LSB +: 2];
      rcv_code = chan[idts_pkg::RCV_LSB +: 2];
    end
  end
endmodule

/* File: hw/idts_sample.sv */
// Ready sampler: counts clocks from strobe assertion to the sample point.
// Assumes the start pulse and the settings arrive together.
`timescale 1ns/1ps
module idts_sample (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] sample_clks,
  input wire logic ready_en,
  input wire logic iordy_pin,
  output logic sample_pulse,
  output logic ready
);
  typedef enum logic [1:0] {
    IDTS_IDLE = 2'h0,
    IDTS_WAIT = 2'h1,
    IDTS_DONE = 2'h3
  } idts_smp_e;

  idts_smp_e st_r, st_nxt; // Sampler state
  logic [2:0] cnt_r, cnt_nxt; // Clocks left to the sample
  logic en_r, en_nxt; // Sampling enable latched at start
  logic pulse_r, pulse_nxt; // Sample strobe
  logic rdy_r, rdy_nxt; // Last sampled ready

  // Next state; a new start always restarts the count
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    en_nxt = en_r;
    pulse_nxt = 1'b0;
    rdy_nxt = rdy_r;
    if (start) begin
      st_nxt = IDTS_WAIT;
      cnt_nxt = sample_clks;
      en_nxt = ready_en;
    end else begin
      case (st_r)
        IDTS_WAIT: begin
          if (cnt_r == 3'h1) begin
            st_nxt = IDTS_DONE;
            pulse_nxt = 1'b1;
            // Disabled sampling forces ready, so the first sample passes
            rdy_nxt = en_r ? iordy_pin : 1'b1;
          end else begin
            cnt_nxt = cnt_r - 3'h1;
          end
        end
        IDTS_DONE: st_nxt = IDTS_IDLE;
        default: st_nxt = IDTS_IDLE;
      endcase
    end
  end

  // Register the sampler state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= IDTS_IDLE;
      cnt_r <= 3'h0;
      en_r <= 1'b0;
      pulse_r <= 1'b0;
      rdy_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      en_r <= en_nxt;
      pulse_r <= pulse_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign sample_pulse = pulse_r;
  assign ready = rdy_r;

  // Start followed by a clean wait
  sequence s_start2;
    start && sample_clks == 3'h2 && !ready_en;
  endsequence
  sequence s_quiet_then_hit;
    !sample_pulse ##1 sample_pulse && ready;
  endsequence

  chk_point_two: assert property (@(posedge clk) disable iff (rst)
    s_start2 ##1 !start ##1 !start |-> s_quiet_then_hit)
    else $error("Sample not two clocks after strobe");
  chk_point_five: assert property (@(posedge clk) disable iff (rst)
    start && sample_clks == 3'h5 ##1 !start [*5] |=> sample_pulse)
    else $error("Sample not five clocks after strobe");
  chk_forced_ready: assert property (@(posedge clk) disable iff (rst)
    sample_pulse && !en_r |-> ready)
    else $error("Ready not forced with sampling off");
  chk_pin_ready: assert property (@(posedge clk) disable iff (rst)
    sample_pulse && en_r |-> ready == $past(iordy_pin))
    else $error("Ready does not follow the pin");
endmodule

/* File: hw/idts_top.sv */
// Per-drive timing selection for one IDE channel.
// Assumes task-file accesses arrive already decoded as in range,
// and a host register port that never waits.
//
// Summary of operation
// - Drive 1 fast bit clear: 16-bit compatible data
// - Drive 1 fast bit set, selected: fast data
// - Drive 1 DMA-only bit forces PIO compatible
// - Non-data ports always 8-bit compatible timing
// - Drive 0 DMA-only bit limits fast to DMA
// - Drive 0 PIO fast only without DMA-only
// - Drive 0 prefetch/posting follows its enable
// - Sampling off forces internal ready asserted
// - Sampling on samples ready at sample point
// - Drive 0 fast bit works like drive 1
// - Slave register idle unless slave enable set
// - Slave timing register at 44h, resets 00h
// - Slave enable gives drive 1 slave timings
// - Sample point codes give 5,4,3,2 clocks
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module idts_top #(
  parameter logic CHAN_SEC = 1'b0 // Picks the secondary slave nibble
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic ACC_REQ,
  input wire logic ACC_DATA_PORT,
  input wire logic ACC_DMA,
  input wire logic ACC_WRITE,
  input wire logic [2:0] ACC_PORT,
  input wire logic [7:0] ACC_WDATA,
  input wire logic IO_STROBE,
  input wire logic IORDY_PIN,
  output logic DRV_SEL,
  output logic ACC_FAST,
  output logic ACC_WIDE16,
  output logic ACC_PREFETCH,
  output logic [2:0] ACC_SAMPLE_CLKS,
  output logic [2:0] ACC_RECOV_CLKS,
  output logic ACC_RDY_EN,
  output logic RDY_SAMPLE,
  output logic RDY_OK
);

  // Configuration registers
  logic [15:0] chan_r, chan_nxt; // Channel drive timing
  logic [7:0] slave_r, slave_nxt; // Slave drive timing

  // Read path
  logic [15:0] rdata_r, rdata_nxt; // Read data, one cycle after strobe

  // Drive select copy
  logic drv_r, drv_nxt; // Copy of the drive/head select bit

  // Latched decision for the current access
  logic fast_r, fast_nxt;
  logic wide_r, wide_nxt;
  logic pf_r, pf_nxt;
  logic [2:0] isp_r, isp_nxt;
  logic [2:0] rcv_r, rcv_nxt;
  logic rdyen_r, rdyen_nxt;

  // Decoder results for the access being offered
  logic dec_fast;
  logic dec_wide;
  logic dec_pf;
  logic [1:0] dec_isp;
  logic [1:0] dec_rcv;
  logic dec_rdyen;

  // Decision is made against the drive selected before this access
  idts_decode u_decode (
    .chan(chan_r),
    .slave(slave_r),
    .sec(CHAN_SEC),
    .drv(drv_r),
    .data_port(ACC_DATA_PORT),
    .dma(ACC_DMA),
    .fast(dec_fast),
    .wide16(dec_wide),
    .prefetch(dec_pf),
    .isp_code(dec_isp),
    .rcv_code(dec_rcv),
    .rdy_en(dec_rdyen)
  );

  // Configuration writes; reserved bits never stored
  always_comb begin
    chan_nxt = chan_r;
    slave_nxt = slave_r;
    if (REG_WR) begin
      case (REG_ADDR)
        idts_pkg::OFS_CHAN: chan_nxt = REG_WDATA & idts_pkg::CHAN_WMASK;
        idts_pkg::OFS_SLAVE: slave_nxt = REG_WDATA[7:0];
        default: chan_nxt = chan_r; // Unmapped writes are dropped
      endcase
    end
  end

  // Register the configuration
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      chan_r <= idts_pkg::RST_CHAN;
      slave_r <= idts_pkg::RST_SLAVE;
    end else begin
      chan_r <= chan_nxt;
      slave_r <= slave_nxt;
    end
  end

  // Read decode; data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 16'h0000;
    if (REG_RD) begin
      case (REG_ADDR)
        idts_pkg::OFS_CHAN: rdata_nxt = chan_r;
        idts_pkg::OFS_SLAVE: rdata_nxt = {8'h00, slave_r};
        // Status shows the block's own view of the channel
        idts_pkg::OFS_STATUS: rdata_nxt = {10'h000, RDY_OK, rdyen_r, pf_r, wide_r, fast_r, drv_r};
        default: rdata_nxt = 16'h0000; // Unmapped reads return zero
      endcase
    end
  end

  // Register the read data
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Snoop drive/head writes to keep the select copy current
  always_comb begin
    drv_nxt = drv_r;
    if (ACC_REQ && ACC_WRITE && !ACC_DATA_PORT && ACC_PORT == idts_pkg::DRVHEAD_PORT) begin
      drv_nxt = ACC_WDATA[idts_pkg::DRVHEAD_SEL_BIT];
    end
  end

  // Register the select copy; drive 0 after reset
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      drv_r <= 1'b0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  // Latch the decision on each access; it holds until the next one
  always_comb begin
    fast_nxt = fast_r;
    wide_nxt = wide_r;
    pf_nxt = pf_r;
    isp_nxt = isp_r;
    rcv_nxt = rcv_r;
    rdyen_nxt = rdyen_r;
    if (ACC_REQ) begin
      fast_nxt = dec_fast;
      wide_nxt = dec_wide;
      pf_nxt = dec_pf;
      // Clock counts go out decoded so the strobe logic needs no table
      isp_nxt = idts_pkg::isp_clks(dec_isp);
      rcv_nxt = idts_pkg::rcv_clks(dec_rcv);
      rdyen_nxt = dec_rdyen;
    end
  end

  // Register the decision; compatible, no sampling after reset
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fast_r <= 1'b0;
      wide_r <= 1'b0;
      pf_r <= 1'b0;
      isp_r <= idts_pkg::ISP_BASE_CLKS;
      rcv_r <= idts_pkg::RCV_BASE_CLKS;
      rdyen_r <= 1'b0;
    end else begin
      fast_r <= fast_nxt;
      wide_r <= wide_nxt;
      pf_r <= pf_nxt;
      isp_r <= isp_nxt;
      rcv_r <= rcv_nxt;
      rdyen_r <= rdyen_nxt;
    end
  end

  // Ready sampler; uses the latched sample point and enable
  idts_sample u_sample (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .start(IO_STROBE),
    .sample_clks(isp_r),
    .ready_en(rdyen_r),
    .iordy_pin(IORDY_PIN),
    .sample_pulse(RDY_SAMPLE),
    .ready(RDY_OK)
  );

  // Outputs, each from a flip-flop
  assign REG_RDATA = rdata_r;
  assign DRV_SEL = drv_r;
  assign ACC_FAST = fast_r;
  assign ACC_WIDE16 = wide_r;
  assign ACC_PREFETCH = pf_r;
  assign ACC_SAMPLE_CLKS = isp_r;
  assign ACC_RECOV_CLKS = rcv_r;
  assign ACC_RDY_EN = rdyen_r;

  // Checks on the decision path
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  // Shorthands for the offered access
  logic data_req;
  logic pio_req;
  assign data_req = ACC_REQ && ACC_DATA_PORT;
  assign pio_req = data_req && !ACC_DMA;

  chk_nondata_compat: assert property (
    ACC_REQ && !ACC_DATA_PORT |=> !ACC_FAST && !ACC_WIDE16 && !ACC_PREFETCH)
    else $error("Non-data port not 8-bit compatible");
  chk_drv1_compat: assert property (
    data_req && drv_r && !chan_r[idts_pkg::BIT_DRV1_FAST] |=> !ACC_FAST && ACC_WIDE16)
    else $error("Drive 1 not compatible with fast bit clear");
  chk_drv1_fast: assert property (
    data_req && drv_r && chan_r[idts_pkg::BIT_DRV1_FAST] && ACC_DMA |=> ACC_FAST)
    else $error("Drive 1 DMA not fast");
  chk_drv1_pio: assert property (
    pio_req && drv_r && chan_r[idts_pkg::BIT_DRV1_FAST] |=> ACC_FAST == !$past(chan_r[idts_pkg::BIT_DRV1_DMAO]))
    else $error("Drive 1 PIO timing ignores DMA-only bit");
  chk_drv0_pio: assert property (
    pio_req && !drv_r && chan_r[idts_pkg::BIT_DRV0_FAST] |=> ACC_FAST == !$past(chan_r[idts_pkg::BIT_DRV0_DMAO]))
    else $error("Drive 0 PIO timing ignores DMA-only bit");
  chk_drv0_fast: assert property (
    data_req && !drv_r |=> ACC_FAST == ($past(chan_r[idts_pkg::BIT_DRV0_FAST])
      && ($past(ACC_DMA) || !$past(chan_r[idts_pkg::BIT_DRV0_DMAO]))))
    else $error("Drive 0 fast bit not honoured");
  chk_drv0_prefetch: assert property (
    data_req && !drv_r |=> ACC_PREFETCH == $past(chan_r[idts_pkg::BIT_DRV0_PP]))
    else $error("Drive 0 prefetch does not follow enable");
  chk_slave_gate: assert property (
    ACC_REQ && !chan_r[idts_pkg::BIT_SLV_EN] |=> ACC_SAMPLE_CLKS == idts_pkg::isp_clks($past(chan_r[13:12])))
    else $error("Slave timing used while disabled");
  chk_devsel_copy: assert property (
    ACC_REQ && ACC_WRITE && !ACC_DATA_PORT && ACC_PORT == idts_pkg::DRVHEAD_PORT
      |=> DRV_SEL == $past(ACC_WDATA[idts_pkg::DRVHEAD_SEL_BIT]))
    else $error("Drive select copy not updated");
  chk_slave_readback: assert property (
    REG_WR && REG_ADDR == idts_pkg::OFS_SLAVE ##1 REG_RD && REG_ADDR == idts_pkg::OFS_SLAVE
      |=> REG_RDATA == {8'h00, $past(REG_WDATA[7:0], 2)})
    else $error("Slave timing register readback wrong");
  chk_read_window: assert property (
    !REG_RD |=> REG_RDATA == 16'h0000)
    else $error("Read data outside its cycle");

  // Drive 0 bank: DMA fast when selected with the fast bit set, fast bit clear means compatible
  chk_drv0_dma_fast: assert property (
    data_req && !drv_r && ACC_DMA && chan_r[idts_pkg::BIT_DRV0_FAST] |=> ACC_FAST)
    else $error("Drive 0 DMA not fast");
  chk_drv0_compat: assert property (
    data_req && !drv_r && !chan_r[idts_pkg::BIT_DRV0_FAST] |=> !ACC_FAST && ACC_WIDE16)
    else $error("Drive 0 not compatible with fast bit clear");
  chk_wide_data: assert property (
    ACC_REQ |=> ACC_WIDE16 == $past(ACC_DATA_PORT))
    else $error("Port width does not follow the port kind");

  // Sampling enable comes from the drive selected before the access
  chk_rdy_en_drv0: assert property (
    ACC_REQ && !drv_r |=> ACC_RDY_EN == $past(chan_r[idts_pkg::BIT_DRV0_RDY]))
    else $error("Drive 0 ready sampling enable not followed");

  // Timing source: slave nibble only for drive 1 with the slave enable set
  chk_slave_used: assert property (
    ACC_REQ && drv_r && chan_r[idts_pkg::BIT_SLV_EN]
      |=> ACC_SAMPLE_CLKS == idts_pkg::isp_clks($past(CHAN_SEC ? slave_r[7:6] : slave_r[3:2]))
      && ACC_RECOV_CLKS == idts_pkg::rcv_clks($past(CHAN_SEC ? slave_r[5:4] : slave_r[1:0])))
    else $error("Drive 1 slave timings not used");
  chk_master_timing: assert property (
    ACC_REQ && !(drv_r && chan_r[idts_pkg::BIT_SLV_EN])
      |=> ACC_SAMPLE_CLKS == idts_pkg::isp_clks($past(chan_r[13:12]))
      && ACC_RECOV_CLKS == idts_pkg::rcv_clks($past(chan_r[9:8])))
    else $error("Main timings not used");
  chk_count_range: assert property (
    ACC_SAMPLE_CLKS >= 3'h2 && ACC_RECOV_CLKS != 3'h0)
    else $error("Timing count out of range");

  // Decision and select copy hold between requests; the strobe logic reads them late
  chk_decision_hold: assert property (
    !ACC_REQ |=> $stable(ACC_FAST) && $stable(ACC_WIDE16) && $stable(ACC_PREFETCH)
      && $stable(ACC_SAMPLE_CLKS) && $stable(ACC_RECOV_CLKS) && $stable(ACC_RDY_EN))
    else $error("Decision changed without a request");
  chk_drv_hold: assert property (
    !(ACC_REQ && ACC_WRITE && !ACC_DATA_PORT && ACC_PORT == idts_pkg::DRVHEAD_PORT) |=> $stable(DRV_SEL))
    else $error("Drive select copy changed without a write");

  // Writes elsewhere must leave both timing registers alone
  chk_unmapped_write: assert property (
    REG_WR && REG_ADDR != idts_pkg::OFS_CHAN && REG_ADDR != idts_pkg::OFS_SLAVE
      |=> $stable(chan_r) && $stable(slave_r))
    else $error("Unmapped write changed a timing register");
endmodule

/* File: pkg/idts_pkg.sv */
// Package for the per-drive timing selection block.
// Assumes one IDE channel per instance, clocked by the PCI clock.
package idts_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFS_CHAN = 8'h40;
  localparam logic [7:0] OFS_SLAVE = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  // Reset values
  localparam logic [15:0] RST_CHAN = 16'h0000;
  localparam logic [7:0] RST_SLAVE = 8'h00;
  // Writable bits of the channel timing register; 15 and 11:10 read zero
  localparam logic [15:0] CHAN_WMASK = 16'h73FF;
  // Channel timing register fields
  localparam int BIT_DRV0_FAST = 0;
  localparam int BIT_DRV0_RDY = 1;
  localparam int BIT_DRV0_PP = 2;
  localparam int BIT_DRV0_DMAO = 3;
  localparam int BIT_DRV1_FAST = 4;
  localparam int BIT_DRV1_RDY = 5;
  localparam int BIT_DRV1_PP = 6;
  localparam int BIT_DRV1_DMAO = 7;
  localparam int RCV_LSB = 8;
  localparam int ISP_LSB = 12;
  localparam int BIT_SLV_EN = 14;
  // Slave timing register fields, per channel nibble
  localparam int SLV_RCV_LSB = 0;
  localparam int SLV_ISP_LSB = 2;
  localparam int SLV_SEC_SHIFT = 4;
  // Drive/head task-file port and its drive select bit
  localparam logic [2:0] DRVHEAD_PORT = 3'h6;
  localparam int DRVHEAD_SEL_BIT = 4;
  // Clock counts for code 00 of each timing field
  localparam logic [2:0] ISP_BASE_CLKS = 3'h5;
  localparam logic [2:0] RCV_BASE_CLKS = 3'h4;

  // Sample point code to PCI clocks from strobe to first sample
  function automatic logic [2:0] isp_clks(input logic [1:0] code);
    isp_clks = ISP_BASE_CLKS - {1'b0, code};
  endfunction

  // Recovery code to PCI clocks
  function automatic logic [2:0] rcv_clks(input logic [1:0] code);
    rcv_clks = RCV_BASE_CLKS - {1'b0, code};
  endfunction
endpackage
